// ### clk_guard_pkg.sv
package clk_guard_pkg;

    // axi4-lite register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SWITCH_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] VIOL_OFS = 8'h0C;
    localparam logic [7:0] STAB_OFS = 8'h10;

    // control register fields
    localparam int CTRL_FAST_HALT_BIT = 0;
    localparam int CTRL_MAIN_HALT_BIT = 1;
    localparam int CTRL_SUB_HALT_BIT = 2;
    localparam int CTRL_PIN_MODE_BIT = 3;
    localparam int CTRL_EXT_SEL_BIT = 4;
    localparam int CTRL_MAIN_SRC_BIT = 5;

    // control reset: every oscillator halted except the fast internal one
    localparam logic [31:0] CTRL_RESET = 32'h0000_0006;

    // status register fields
    localparam int STAT_MAIN_SRC_BIT = 0;
    localparam int STAT_CPU_SRC_BIT = 1;
    localparam int STAT_CPU_SEL_LSB = 2;
    localparam int STAT_STABLE_BIT = 5;
    localparam int STAT_BUSY_BIT = 6;

    // violation register fields (sticky, write one to clear)
    localparam int VIOL_HALT_BIT = 0;
    localparam int VIOL_SWITCH_BIT = 1;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // default crystal stabilization time in cycles
    localparam logic [15:0] STAB_RESET = 16'h0100;

    // cpu clock targets
    typedef enum logic [2:0] {
        SRC_FAST_INT = 3'b000,
        SRC_MAIN_XTAL = 3'b001,
        SRC_MAIN_EXT = 3'b010,
        SRC_SUB_XTAL = 3'b011,
        SRC_SUB_EXT = 3'b100
    } clk_src_t;

    function automatic logic is_sub(input logic [2:0] s);
        return (s == SRC_SUB_XTAL) || (s == SRC_SUB_EXT);
    endfunction

endpackage

// ### clk_guard_if.sv
`timescale 1ns/100ps
interface clk_guard_if;
    logic main_osc_halt;
    logic fast_internal_osc_halt;
    logic main_osc_pin_mode;
    logic main_external_input_select;
    logic main_clock_source_status;
    logic [15:0] stab_cycles;
    logic stable;
    modport ctrl (
        output main_osc_halt, fast_internal_osc_halt, main_osc_pin_mode,
        output main_external_input_select, main_clock_source_status, stab_cycles,
        input stable
    );
    modport timer (
        input main_osc_halt, fast_internal_osc_halt, main_osc_pin_mode,
        input main_external_input_select, main_clock_source_status, stab_cycles,
        output stable
    );
endinterface

// ### stab_timer.sv
`timescale 1ns/100ps
module stab_timer (
    input wire logic sys_clk,
    input wire logic rst,
    clk_guard_if.timer g
);
    import clk_guard_pkg::*;

    logic [15:0] count_q;
    logic stable_q;
    logic run;

    // crystal runs only in oscillator pin mode with the crystal input chosen
    assign run = !g.main_osc_halt && g.main_osc_pin_mode && !g.main_external_input_select;

    // count restarts whenever the crystal is halted again
    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            count_q <= 16'h0000;
            stable_q <= 1'b0;
        end else if (count_q >= g.stab_cycles) begin
            stable_q <= 1'b1;
        end else begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign g.stable = stable_q;
endmodule

// ### cpu_clock_switch_guard.sv
`timescale 1ns/100ps
module cpu_clock_switch_guard (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic fast_internal_osc_halt,
    output logic main_osc_halt,
    output logic sub_osc_halt,
    output logic main_osc_pin_mode,
    output logic main_external_input_select,
    output logic main_clock_source_status,
    output logic cpu_clock_source_status,
    output logic [2:0] cpu_clock_select
);
    import clk_guard_pkg::*;

    clk_guard_if g ();

    stab_timer u_stab (
        .sys_clk(sys_clk),
        .rst(rst),
        .g(g.timer)
    );

    logic [5:0] ctrl_q;
    logic [2:0] cpu_sel_q;
    logic [1:0] viol_q;
    logic [15:0] stab_q;
    logic sub_ext_q;
    logic pend_q;
    logic [2:0] pend_tgt_q;

    logic aw_held_q, w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    logic wr_fire;
    logic main_src_d, cpu_src;
    logic halt_viol, switch_viol;
    logic [5:0] ctrl_d;
    logic switch_req;
    logic [2:0] switch_tgt;
    logic switch_ok;

    // one write landing on one register offset; shared by every register write decode
    function automatic logic wr_hit(input logic fire, input logic [7:0] addr,
                                    input logic [7:0] ofs);
        return fire && addr == ofs;
    endfunction

    assign cpu_src = is_sub(cpu_sel_q);

    // write channel: address and data taken in any order, response after both
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // control write with halt guard
    always_comb begin
        ctrl_d = ctrl_q;
        halt_viol = 1'b0;
        if (wr_hit(wr_fire, awaddr_q, CTRL_OFS) && wstrb_q[0]) begin
            ctrl_d = wdata_q[5:0];
            main_src_d = wdata_q[CTRL_MAIN_SRC_BIT];
            // main source status may only move while its target runs
            if (main_src_d != ctrl_q[CTRL_MAIN_SRC_BIT]) begin
                if (main_src_d ? ctrl_q[CTRL_MAIN_HALT_BIT]
                               : ctrl_q[CTRL_FAST_HALT_BIT]) begin
                    ctrl_d[CTRL_MAIN_SRC_BIT] = ctrl_q[CTRL_MAIN_SRC_BIT];
                    halt_viol = 1'b1;
                end
            end
            if (ctrl_d[CTRL_FAST_HALT_BIT] && !ctrl_q[CTRL_FAST_HALT_BIT]
                && !(ctrl_d[CTRL_MAIN_SRC_BIT] || cpu_src)) begin
                ctrl_d[CTRL_FAST_HALT_BIT] = 1'b0;
                halt_viol = 1'b1;
            end
            if (ctrl_d[CTRL_MAIN_HALT_BIT] && !ctrl_q[CTRL_MAIN_HALT_BIT]
                && !(!ctrl_d[CTRL_MAIN_SRC_BIT] || cpu_src)) begin
                ctrl_d[CTRL_MAIN_HALT_BIT] = 1'b0;
                halt_viol = 1'b1;
            end
            // pin mode and input select frozen while the main source may be in use
            if (!ctrl_q[CTRL_MAIN_HALT_BIT] && ctrl_q[CTRL_MAIN_SRC_BIT]) begin
                ctrl_d[CTRL_PIN_MODE_BIT] = ctrl_q[CTRL_PIN_MODE_BIT];
                ctrl_d[CTRL_EXT_SEL_BIT] = ctrl_q[CTRL_EXT_SEL_BIT];
            end
            if (ctrl_d[CTRL_SUB_HALT_BIT] && !ctrl_q[CTRL_SUB_HALT_BIT]
                && cpu_src) begin
                ctrl_d[CTRL_SUB_HALT_BIT] = 1'b0;
                halt_viol = 1'b1;
            end
        end else begin
            main_src_d = ctrl_q[CTRL_MAIN_SRC_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET[5:0];
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stab_q <= STAB_RESET;
            sub_ext_q <= 1'b0;
        end else if (wr_hit(wr_fire, awaddr_q, STAB_OFS)) begin
            if (wstrb_q[0]) stab_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) stab_q[15:8] <= wdata_q[15:8];
            if (wstrb_q[2]) sub_ext_q <= wdata_q[16];
        end
    end

    // switch request and its preconditions
    assign switch_req = wr_hit(wr_fire, awaddr_q, SWITCH_OFS) && wstrb_q[0];
    assign switch_tgt = wdata_q[2:0];

    always_comb begin
        switch_ok = 1'b0;
        case (switch_tgt)
            SRC_FAST_INT: switch_ok = !ctrl_q[CTRL_FAST_HALT_BIT]
                && !ctrl_q[CTRL_MAIN_SRC_BIT];
            SRC_MAIN_XTAL: switch_ok = ctrl_q[CTRL_PIN_MODE_BIT]
                && !ctrl_q[CTRL_EXT_SEL_BIT] && !ctrl_q[CTRL_MAIN_HALT_BIT]
                && ctrl_q[CTRL_MAIN_SRC_BIT];
            SRC_MAIN_EXT: switch_ok = ctrl_q[CTRL_PIN_MODE_BIT]
                && ctrl_q[CTRL_EXT_SEL_BIT] && !ctrl_q[CTRL_MAIN_HALT_BIT]
                && ctrl_q[CTRL_MAIN_SRC_BIT];
            SRC_SUB_XTAL: switch_ok = !cpu_src && !ctrl_q[CTRL_SUB_HALT_BIT] && !sub_ext_q;
            SRC_SUB_EXT: switch_ok = !cpu_src && !ctrl_q[CTRL_SUB_HALT_BIT] && sub_ext_q;
            default: switch_ok = 1'b0;
        endcase
        // sub crystal and external sub clock never swap directly
        if (cpu_src && is_sub(switch_tgt) && switch_tgt != cpu_sel_q) begin
            switch_ok = 1'b0;
        end
    end

    assign switch_viol = switch_req && !switch_ok;

    // main crystal target waits for the stabilization timer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_sel_q <= SRC_FAST_INT;
            pend_q <= 1'b0;
            pend_tgt_q <= SRC_FAST_INT;
        end else if (pend_q) begin
            if (ctrl_q[CTRL_MAIN_HALT_BIT] || !ctrl_q[CTRL_MAIN_SRC_BIT]) begin
                pend_q <= 1'b0; // abandoned when preconditions drop
            end else if (g.stable) begin
                cpu_sel_q <= pend_tgt_q;
                pend_q <= 1'b0;
            end
        end else if (switch_req && switch_ok) begin
            if (switch_tgt == SRC_MAIN_XTAL && !g.stable) begin
                pend_q <= 1'b1;
                pend_tgt_q <= switch_tgt;
            end else begin
                cpu_sel_q <= switch_tgt;
            end
        end
    end

    // sticky violations: set wins over write-one clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            viol_q <= 2'b00;
        end else begin
            viol_q[VIOL_HALT_BIT] <= halt_viol || (viol_q[VIOL_HALT_BIT]
                && !(wr_hit(wr_fire, awaddr_q, VIOL_OFS) && wdata_q[VIOL_HALT_BIT]));
            viol_q[VIOL_SWITCH_BIT] <= switch_viol || (viol_q[VIOL_SWITCH_BIT]
                && !(wr_hit(wr_fire, awaddr_q, VIOL_OFS) && wdata_q[VIOL_SWITCH_BIT]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q > STAB_OFS || awaddr_q[1:0] != 2'b00)
                ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel: one cycle from address to data
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            case (s_axi_araddr)
                CTRL_OFS: rdata_q <= {26'h0, ctrl_q};
                SWITCH_OFS: rdata_q <= {29'h0, cpu_sel_q};
                STATUS_OFS: rdata_q <= {25'h0, pend_q, g.stable, cpu_sel_q,
                    cpu_src, ctrl_q[CTRL_MAIN_SRC_BIT]};
                VIOL_OFS: rdata_q <= {30'h0, viol_q};
                STAB_OFS: rdata_q <= {15'h0, sub_ext_q, stab_q};
                default: rresp_q <= RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign g.main_osc_halt = ctrl_q[CTRL_MAIN_HALT_BIT];
    assign g.fast_internal_osc_halt = ctrl_q[CTRL_FAST_HALT_BIT];
    assign g.main_osc_pin_mode = ctrl_q[CTRL_PIN_MODE_BIT];
    assign g.main_external_input_select = ctrl_q[CTRL_EXT_SEL_BIT];
    assign g.main_clock_source_status = ctrl_q[CTRL_MAIN_SRC_BIT];
    assign g.stab_cycles = stab_q;

    assign fast_internal_osc_halt = ctrl_q[CTRL_FAST_HALT_BIT];
    assign main_osc_halt = ctrl_q[CTRL_MAIN_HALT_BIT];
    assign sub_osc_halt = ctrl_q[CTRL_SUB_HALT_BIT];
    assign main_osc_pin_mode = ctrl_q[CTRL_PIN_MODE_BIT];
    assign main_external_input_select = ctrl_q[CTRL_EXT_SEL_BIT];
    assign main_clock_source_status = ctrl_q[CTRL_MAIN_SRC_BIT];
    assign cpu_clock_source_status = cpu_src;
    assign cpu_clock_select = cpu_sel_q;
endmodule

// ### clk_guard_monitor.sv
`timescale 1ns/100ps
module clk_guard_monitor #(
    parameter int STAB_CYC = int'(clk_guard_pkg::STAB_RESET)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fast_internal_osc_halt,
    input wire logic main_osc_halt,
    input wire logic sub_osc_halt,
    input wire logic main_osc_pin_mode,
    input wire logic main_external_input_select,
    input wire logic main_clock_source_status,
    input wire logic cpu_clock_source_status,
    input wire logic [2:0] cpu_clock_select
);
    import clk_guard_pkg::*;
    // cycles since main oscillator enable; loose margin, design may count from a later point
    logic [15:0] run_cnt_q;
    always_ff @(posedge sys_clk) begin
        if (rst || main_osc_halt) begin
            run_cnt_q <= 16'h0;
        end else if (run_cnt_q != 16'hffff) begin
            run_cnt_q <= run_cnt_q + 16'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence left_sub_to(logic [2:0] tgt);
        $past(cpu_clock_source_status) && cpu_clock_select == tgt;
    endsequence
    sequence main_ready(logic ext);
        $past(main_osc_pin_mode && main_external_input_select == ext && !main_osc_halt
            && main_clock_source_status);
    endsequence
    AST_FAST_FROM_SUB: assert property (left_sub_to(SRC_FAST_INT) |->
        $past(!fast_internal_osc_halt && !main_clock_source_status))
        else $error("cpu moved to fast internal clock while not ready");
    AST_XTAL_FROM_SUB: assert property (left_sub_to(SRC_MAIN_XTAL) |-> main_ready(1'b0))
        else $error("cpu moved to main crystal while not ready");
    AST_EXT_FROM_SUB: assert property (left_sub_to(SRC_MAIN_EXT) |-> main_ready(1'b1))
        else $error("cpu moved to external main clock while not ready");
    AST_XTAL_STABLE: assert property ($changed(cpu_clock_select)
        && cpu_clock_select == SRC_MAIN_XTAL |-> run_cnt_q >= STAB_CYC - 2)
        else $error("main crystal selected before stabilization");
    AST_FAST_HALT_SAFE: assert property ($rose(fast_internal_osc_halt) |->
        main_clock_source_status || cpu_clock_source_status)
        else $error("fast internal oscillator halted while in use");
    AST_MAIN_HALT_SAFE: assert property ($rose(main_osc_halt) |->
        !main_clock_source_status || cpu_clock_source_status)
        else $error("main oscillator halted while in use");
    AST_SUB_HALT_SAFE: assert property ($rose(sub_osc_halt) |-> !cpu_clock_source_status)
        else $error("sub oscillator halted while in use");
    AST_NO_SUB_HOP: assert property ($past(cpu_clock_source_status)
        && cpu_clock_source_status |-> $stable(cpu_clock_select))
        else $error("direct change between sub sources");
    AST_ACTIVE_RUNS: assert property (!cpu_clock_source_status |->
        (main_clock_source_status ? !main_osc_halt : !fast_internal_osc_halt))
        else $error("selected main system clock is halted");
endmodule
bind cpu_clock_switch_guard clk_guard_monitor mon (.*);

// ### cpu_clock_switch_guard_bench.sv
`timescale 1ns/100ps
module cpu_clock_switch_guard_bench;
    import clk_guard_pkg::*;
    logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic fast_internal_osc_halt, main_osc_halt, sub_osc_halt, main_osc_pin_mode;
    logic main_external_input_select, main_clock_source_status, cpu_clock_source_status;
    logic [2:0] cpu_clock_select, tgt;
    logic [5:0] cur, rnd;
    logic ok;
    int err_count, num_checks;

    cpu_clock_switch_guard uut (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_sel(input logic [2:0] exp, input int lim);
        for (int i = 0; i < lim && cpu_clock_select !== exp; i++) @(posedge sys_clk);
    endtask

    // control bits: 0 fast halt, 1 main halt, 3 pin mode, 4 ext select, 5 main status
    function automatic logic sw_ok(input logic [2:0] t, input logic [5:0] c);
        case (t)
            SRC_FAST_INT: return !c[0] && !c[5];
            SRC_MAIN_XTAL: return c[3] && !c[4] && !c[1] && c[5];
            default: return c[3] && c[4] && !c[1] && c[5];
        endcase
    endfunction

    initial begin
        #500_000;
        err_count++;
        close_out();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        rst = 1'b1;
        err_count = 0;
        num_checks = 0;
        rnd = 6'($urandom(21));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        bus_rd(CTRL_OFS);
        chk(rd, CTRL_RESET);
        bus_rd(8'h14);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        bus_wr(CTRL_OFS, 32'h7);
        bus_rd(CTRL_OFS);
        chk(rd, CTRL_RESET);
        bus_wr(VIOL_OFS, 32'h3);
        cur = 6'h02;
        bus_wr(CTRL_OFS, 32'h2);
        bus_wr(SWITCH_OFS, {29'h0, SRC_SUB_XTAL});
        wait_sel(SRC_SUB_XTAL, 20);
        chk({29'h0, cpu_clock_select}, {29'h0, SRC_SUB_XTAL});
        bus_wr(SWITCH_OFS, {29'h0, SRC_SUB_EXT});
        repeat (20) @(posedge sys_clk);
        chk({29'h0, cpu_clock_select}, {29'h0, SRC_SUB_XTAL});
        bus_wr(CTRL_OFS, 32'h6);
        bus_rd(CTRL_OFS);
        chk(rd, 32'h2);
        bus_rd(VIOL_OFS);
        chk(rd, 32'h3);
        bus_wr(VIOL_OFS, 32'h3);
        for (int i = 0; i < 16; i++) begin
            // first three passes are the corner cases, one per target
            rnd = (i == 0) ? 6'h28 : (i == 1) ? 6'h38 : (i == 2) ? 6'h00 : 6'($urandom());
            tgt = (i < 3) ? 3'(i) : 3'($urandom_range(2));
            cur[1:0] = 2'b00;
            bus_wr(CTRL_OFS, {26'h0, cur});
            cur[5] = 1'b0;
            bus_wr(CTRL_OFS, {26'h0, cur});
            cur = {1'b0, rnd[4:3], 1'b0, rnd[1:0]};
            bus_wr(CTRL_OFS, {26'h0, cur});
            cur[5] = rnd[5] && !rnd[1];
            bus_wr(CTRL_OFS, {26'h0, rnd[5], cur[4:0]});
            bus_rd(CTRL_OFS);
            chk(rd, {26'h0, cur});
            chk({26'h0, main_clock_source_status, main_external_input_select, main_osc_pin_mode,
                sub_osc_halt, main_osc_halt, fast_internal_osc_halt}, {26'h0, cur});
            ok = sw_ok(tgt, cur);
            bus_wr(SWITCH_OFS, {29'h0, tgt});
            wait_sel(ok ? tgt : SRC_SUB_XTAL, ok ? 600 : 20);
            chk({29'h0, cpu_clock_select}, {29'h0, ok ? tgt : SRC_SUB_XTAL});
            bus_rd(STATUS_OFS);
            chk(rd & 32'h5f, {27'h0, ok ? tgt : SRC_SUB_XTAL, !ok, cur[5]});
            chk({31'h0, cpu_clock_source_status}, {31'h0, !ok});
            bus_rd(VIOL_OFS);
            chk(rd, {30'h0, !ok, rnd[5] && rnd[1]});
            bus_wr(VIOL_OFS, 32'h3);
            if (ok) begin
                bus_wr(CTRL_OFS, {26'h0, cur | ((tgt == SRC_FAST_INT) ? 6'h1 : 6'h2)});
                bus_rd(CTRL_OFS);
                chk(rd, {26'h0, cur});
                bus_wr(VIOL_OFS, 32'h3);
                bus_wr(SWITCH_OFS, {29'h0, SRC_SUB_XTAL});
                wait_sel(SRC_SUB_XTAL, 20);
                chk({29'h0, cpu_clock_select}, {29'h0, SRC_SUB_XTAL});
            end
        end
        // external sub clock: only disabled once the cpu has left it
        bus_wr(CTRL_OFS, {26'h0, cur & 6'h20});
        bus_wr(CTRL_OFS, 32'h0);
        bus_wr(STAB_OFS, {15'h0, 1'b1, STAB_RESET});
        bus_wr(SWITCH_OFS, {29'h0, SRC_FAST_INT});
        wait_sel(SRC_FAST_INT, 20);
        bus_wr(SWITCH_OFS, {29'h0, SRC_SUB_EXT});
        wait_sel(SRC_SUB_EXT, 20);
        chk({29'h0, cpu_clock_select}, {29'h0, SRC_SUB_EXT});
        bus_wr(CTRL_OFS, 32'h4);
        chk({31'h0, sub_osc_halt}, 32'h0);
        bus_wr(SWITCH_OFS, {29'h0, SRC_FAST_INT});
        wait_sel(SRC_FAST_INT, 20);
        chk({31'h0, cpu_clock_source_status}, 32'h0);
        bus_wr(CTRL_OFS, 32'h4);
        chk({31'h0, sub_osc_halt}, 32'h1);
        close_out();
    end
endmodule
